// [logic/sle_pkg.sv]
// Constants, register map and types of the sleep and literal-subtract executor.
// Assumes a single 250 MHz core clock and an AXI4-Lite master with 32-bit data.
// Function
// - The low-power entry instruction is recognised by its fixed 14-bit opcode, one word, one cycle.
// - Executing it clears the guard timer count and the guard timer prescaler.
// - Executing it sets the active-low timeout flag to one and clears the active-low sleep flag.
// - It decodes in phase one, idles in phases two and three and halts in phase four.
// - While halted by it, the oscillator is kept stopped.
// - The literal-minus-accumulator instruction decodes from prefix 11 110x with an 8-bit immediate.
// - It computes immediate minus accumulator and writes the difference to the accumulator.
// - The subtraction adds the two's complement of the accumulator to the immediate.
// - It updates borrow, nibble borrow and zero flags and leaves other status bits alone.
// - It decodes in phase one, reads the immediate in two, computes in three, writes in four.
// - The borrow flag is cleared for a negative result, which wraps, and set otherwise.
package sle_pkg;

  localparam logic [7:0]  ADR_INSTR    = 8'h00;
  localparam logic [7:0]  ADR_ACC      = 8'h04;
  localparam logic [7:0]  ADR_STATUS   = 8'h08;
  localparam logic [7:0]  ADR_WAKE     = 8'h0c;
  localparam logic [7:0]  ADR_GUARD    = 8'h10;

  localparam logic [13:0] OP_SLEEP     = 14'h0063;
  localparam logic [4:0]  OP_SUB_PFX   = 5'h1e;
  localparam int          OP_PFX_LSB   = 9;

  localparam int          ST_CARRY     = 0;
  localparam int          ST_HALF      = 1;
  localparam int          ST_ZERO      = 2;
  localparam int          ST_SLEEP_N   = 3;
  localparam int          ST_TOUT_N    = 4;
  localparam int          ST_HALTED    = 5;
  localparam int          ST_BUSY      = 6;
  localparam int          ST_BADOP     = 7;

  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [13:0] INSTR_RST    = 14'h0000;
  localparam logic [7:0]  PRE_RST      = 8'h00;
  localparam logic [7:0]  GUARD_RST    = 8'h00;
  localparam logic [7:0]  PRE_MAX      = 8'hff;
  localparam logic [7:0]  GUARD_MAX    = 8'hff;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROC,
    PH_WRITE
  } sle_phase_type;

  typedef enum logic [1:0] {
    OPK_NONE,
    OPK_SLEEP,
    OPK_SUB
  } sle_opk_type;

endpackage : sle_pkg

// [logic/sle_phase_seq.sv]
// Four-phase sequencer: one phase per core clock for one instruction cycle.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module sle_phase_seq (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_start,
  output logic                        o_active,
  output sle_pkg::sle_phase_type      o_phase
);

  typedef struct packed {
    logic                   active;
    sle_pkg::sle_phase_type phase;
  } sle_seq_type;

  sle_seq_type seq_reg;
  sle_seq_type seq_next;

  always_comb begin
    seq_next = seq_reg;
    if (seq_reg.active) begin
      unique case (seq_reg.phase)
        sle_pkg::PH_DECODE: seq_next.phase = sle_pkg::PH_READ;
        sle_pkg::PH_READ:   seq_next.phase = sle_pkg::PH_PROC;
        sle_pkg::PH_PROC:   seq_next.phase = sle_pkg::PH_WRITE;
        sle_pkg::PH_WRITE:  seq_next.active = 1'b0;
      endcase
    end else if (i_start) begin
      seq_next.active = 1'b1;
      seq_next.phase  = sle_pkg::PH_DECODE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      seq_reg <= '{active: 1'b0, phase: sle_pkg::PH_DECODE};
    end else begin
      seq_reg <= seq_next;
    end
  end

  assign o_active = seq_reg.active;
  assign o_phase  = seq_reg.phase;

endmodule : sle_phase_seq

// [logic/sle_lit_sub.sv]
// Combinational literal minus accumulator datapath with its three flags.
// Assumes both operands are stable for the phase in which the result is taken.
`timescale 1ns/1ps
module sle_lit_sub (
  input  wire logic [7:0] i_lit,
  input  wire logic [7:0] i_acc,
  output logic      [7:0] o_diff,
  output logic            o_carry,
  output logic            o_half,
  output logic            o_zero
);

  logic [8:0] sum;
  logic [4:0] low;

  assign sum     = {1'b0, i_lit} + {1'b0, ~i_acc} + 9'h001;
  assign low     = {1'b0, i_lit[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
  assign o_diff  = sum[7:0];
  assign o_carry = sum[8];
  assign o_half  = low[4];
  assign o_zero  = (sum[7:0] == 8'h00);

endmodule : sle_lit_sub

// [logic/sle_exec.sv]
// Executor for the low-power entry and literal-minus-accumulator instructions.
// Assumes an AXI4-Lite master on i_clk_sys with one write and one read in flight.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module sle_exec (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic             o_osc_run,
  output logic             o_halted,
  output logic             o_guard_expire
);

  typedef struct packed {
    logic                 aw_got;
    logic [7:0]           aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [13:0]          instr;
    sle_pkg::sle_opk_type opk;
    logic [7:0]           operand;
    logic [7:0]           res;
    logic                 res_carry;
    logic                 res_half;
    logic                 res_zero;
    logic [7:0]           acc;
    logic                 carry_flag;
    logic                 half_borrow_not_flag;
    logic                 zero_flag;
    logic                 sleep_entered_flag_n;
    logic                 timeout_flag_n;
    logic                 halted;
    logic                 badop;
    logic [7:0]           prescale;
    logic [7:0]           guard_timer;
    logic                 expire;
  } sle_state_type;

  sle_state_type          st_reg;
  sle_state_type          st_next;
  logic                   go;
  logic                   busy;
  sle_pkg::sle_phase_type phase;
  logic                   phase_four;
  logic [7:0]             sub_diff;
  logic                   sub_carry;
  logic                   sub_half;
  logic                   sub_zero;
  logic [7:0]             status_byte;

  sle_phase_seq u_phase (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_start   (go),
    .o_active  (busy),
    .o_phase   (phase)
  );

  sle_lit_sub u_sub (
    .i_lit   (st_reg.operand),
    .i_acc   (st_reg.acc),
    .o_diff  (sub_diff),
    .o_carry (sub_carry),
    .o_half  (sub_half),
    .o_zero  (sub_zero)
  );

  assign phase_four = busy && (phase == sle_pkg::PH_WRITE);

  always_comb begin
    status_byte                        = 8'h00;
    status_byte[sle_pkg::ST_CARRY]     = st_reg.carry_flag;
    status_byte[sle_pkg::ST_HALF]      = st_reg.half_borrow_not_flag;
    status_byte[sle_pkg::ST_ZERO]      = st_reg.zero_flag;
    status_byte[sle_pkg::ST_SLEEP_N]   = st_reg.sleep_entered_flag_n;
    status_byte[sle_pkg::ST_TOUT_N]    = st_reg.timeout_flag_n;
    status_byte[sle_pkg::ST_HALTED]    = st_reg.halted;
    status_byte[sle_pkg::ST_BUSY]      = busy;
    status_byte[sle_pkg::ST_BADOP]     = st_reg.badop;
  end

  // Write channels are held off until the pending response is taken.
  assign o_s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign o_s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign o_s_axi_arready = !st_reg.rvalid;

  always_comb begin
    st_next        = st_reg;
    go             = 1'b0;
    st_next.expire = 1'b0;

    // Address and data may arrive in either order.
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = i_s_axi_wdata;
      st_next.w_strb = i_s_axi_wstrb;
    end
    if (st_reg.bvalid && i_s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Register write, once both halves are held.
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = sle_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        sle_pkg::ADR_INSTR: begin
          // A new instruction starts only when idle and awake.
          if (&st_reg.w_strb[1:0] && !busy && !st_reg.halted) begin
            st_next.instr = st_reg.w_data[13:0];
            go            = 1'b1;
          end
        end
        sle_pkg::ADR_ACC: begin
          if (st_reg.w_strb[0]) begin
            st_next.acc = st_reg.w_data[7:0];
          end
        end
        sle_pkg::ADR_STATUS: begin
          if (st_reg.w_strb[0]) begin
            st_next.carry_flag           = st_reg.w_data[sle_pkg::ST_CARRY];
            st_next.half_borrow_not_flag = st_reg.w_data[sle_pkg::ST_HALF];
            st_next.zero_flag            = st_reg.w_data[sle_pkg::ST_ZERO];
            st_next.sleep_entered_flag_n = st_reg.w_data[sle_pkg::ST_SLEEP_N];
            st_next.timeout_flag_n       = st_reg.w_data[sle_pkg::ST_TOUT_N];
            st_next.badop                = st_reg.w_data[sle_pkg::ST_BADOP];
          end
        end
        sle_pkg::ADR_WAKE: begin
          if (st_reg.w_strb[0] && st_reg.w_data[0]) begin
            st_next.halted = 1'b0;
          end
        end
        sle_pkg::ADR_GUARD: begin
          // The guard timer count is read only.
        end
        default: begin
          st_next.bresp = sle_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel answers one cycle after the address is taken.
    if (st_reg.rvalid && i_s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = sle_pkg::RESP_OKAY;
      unique case (i_s_axi_araddr)
        sle_pkg::ADR_INSTR:  st_next.rdata = {18'h00000, st_reg.instr};
        sle_pkg::ADR_ACC:    st_next.rdata = {24'h000000, st_reg.acc};
        sle_pkg::ADR_STATUS: st_next.rdata = {24'h000000, status_byte};
        sle_pkg::ADR_WAKE:   st_next.rdata = 32'h0000_0000;
        sle_pkg::ADR_GUARD:  st_next.rdata = {24'h000000, st_reg.guard_timer};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = sle_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Guard timer advances through its prescaler once every 256 core clocks.
    st_next.prescale = st_reg.prescale + 8'h01;
    if (st_reg.prescale == sle_pkg::PRE_MAX) begin
      st_next.guard_timer = st_reg.guard_timer + 8'h01;
      if (st_reg.guard_timer == sle_pkg::GUARD_MAX) begin
        st_next.expire         = 1'b1;
        st_next.timeout_flag_n = 1'b0;
        st_next.halted         = 1'b0;
      end
    end

    // Instruction phases; these updates win over a same-cycle software write.
    if (busy) begin
      unique case (phase)
        sle_pkg::PH_DECODE: begin
          if (st_reg.instr == sle_pkg::OP_SLEEP) begin
            st_next.opk = sle_pkg::OPK_SLEEP;
          end else if (st_reg.instr[13:sle_pkg::OP_PFX_LSB] == sle_pkg::OP_SUB_PFX) begin
            st_next.opk = sle_pkg::OPK_SUB;
          end else begin
            st_next.opk   = sle_pkg::OPK_NONE;
            st_next.badop = 1'b1;
          end
        end
        sle_pkg::PH_READ: begin
          if (st_reg.opk == sle_pkg::OPK_SUB) begin
            st_next.operand = st_reg.instr[7:0];
          end
        end
        sle_pkg::PH_PROC: begin
          if (st_reg.opk == sle_pkg::OPK_SUB) begin
            st_next.res       = sub_diff;
            st_next.res_carry = sub_carry;
            st_next.res_half  = sub_half;
            st_next.res_zero  = sub_zero;
          end
        end
        sle_pkg::PH_WRITE: begin
          if (st_reg.opk == sle_pkg::OPK_SUB) begin
            st_next.acc                  = st_reg.res;
            st_next.carry_flag           = st_reg.res_carry;
            st_next.half_borrow_not_flag = st_reg.res_half;
            st_next.zero_flag            = st_reg.res_zero;
          end else if (st_reg.opk == sle_pkg::OPK_SLEEP) begin
            st_next.prescale             = sle_pkg::PRE_RST;
            st_next.guard_timer          = sle_pkg::GUARD_RST;
            st_next.expire               = 1'b0;
            st_next.timeout_flag_n       = 1'b1;
            st_next.sleep_entered_flag_n = 1'b0;
            st_next.halted               = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st_reg                      <= '0;
      st_reg.instr                <= sle_pkg::INSTR_RST;
      st_reg.opk                  <= sle_pkg::OPK_NONE;
      st_reg.acc                  <= sle_pkg::ACC_RST;
      st_reg.sleep_entered_flag_n <= 1'b1;
      st_reg.timeout_flag_n       <= 1'b1;
      st_reg.prescale             <= sle_pkg::PRE_RST;
      st_reg.guard_timer          <= sle_pkg::GUARD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_s_axi_bvalid = st_reg.bvalid;
  assign o_s_axi_bresp  = st_reg.bresp;
  assign o_s_axi_rvalid = st_reg.rvalid;
  assign o_s_axi_rdata  = st_reg.rdata;
  assign o_s_axi_rresp  = st_reg.rresp;
  assign o_osc_run      = !st_reg.halted;
  assign o_halted       = st_reg.halted;
  assign o_guard_expire = st_reg.expire;

endmodule : sle_exec

// [testbench/sle_exec_asserts.sv]
// Port checker for the sleep and literal-subtract executor.
// Assumes it is bound onto sle_exec with one core clock and synchronous reset.
`timescale 1ns/1ps
module sle_exec_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  input wire logic [7:0]  i_s_axi_awaddr,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0]  i_s_axi_wstrb,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic [7:0]  i_s_axi_araddr,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0]  o_s_axi_rresp,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic        o_osc_run,
  input wire logic        o_halted,
  input wire logic        o_guard_expire
);
  logic sleep_wr;
  logic rd_take;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // The sleep opcode offered on both write channels at once.
  assign sleep_wr = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready &&
                    i_s_axi_awaddr == sle_pkg::ADR_INSTR && i_s_axi_wstrb[1:0] == 2'h3 &&
                    i_s_axi_wdata[13:0] == sle_pkg::OP_SLEEP && !o_halted;
  assign rd_take = i_s_axi_arvalid && o_s_axi_arready;
  property p_osc; o_osc_run != o_halted; endproperty
  a_osc: assert property (p_osc) else $error("oscillator runs while halted");
  property p_sleep; sleep_wr |=> (!o_halted) [*3] ##[1:3] o_halted; endproperty
  a_sleep: assert property (p_sleep) else $error("halt not in phase four");
  property p_hstay;
    o_halted && !i_s_axi_awvalid && !i_s_axi_wvalid
      |=> o_halted || o_guard_expire || $past(o_guard_expire) || $rose(o_s_axi_bvalid);
  endproperty
  a_hstay: assert property (p_hstay) else $error("halt left without cause");
  property p_gpulse; o_guard_expire |=> !o_guard_expire; endproperty
  a_gpulse: assert property (p_gpulse) else $error("expire longer than one cycle");
  property p_bhold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_wbusy; o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready; endproperty
  a_wbusy: assert property (p_wbusy) else $error("write taken during response");
  property p_rlat; rd_take |=> o_s_axi_rvalid && !o_s_axi_arready; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_runmap;
    rd_take && i_s_axi_araddr > sle_pkg::ADR_GUARD
      |=> o_s_axi_rresp == sle_pkg::RESP_SLVERR && o_s_axi_rdata == 32'h0;
  endproperty
  a_runmap: assert property (p_runmap) else $error("unmapped read answered");
endmodule : sle_exec_asserts

bind sle_exec sle_exec_asserts i_sle_exec_asserts (.*);

// [testbench/sle_exec_bench.sv]
// Self-checking bench for the sleep and literal-subtract executor.
// Assumes an AXI4-Lite slave with 32-bit data on one 4 ns clock.
`timescale 1ns/1ps
module sle_exec_bench;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, osc_run, halted, gexp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          num_errors, compares, n;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  sle_exec i_sle_exec (
    .i_clk_sys(clk), .i_rst_b(rst_b),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_osc_run(osc_run),
    .o_halted(halted), .o_guard_expire(gexp)
  );

  task print_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : idle

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 100) begin
      num_errors++;
      print_verdict();
    end
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 100) begin
      num_errors++;
      print_verdict();
    end
  endtask : axi_rd

  task t_sub;
    logic [7:0]  k [5];
    logic [7:0]  w [5];
    logic [7:0]  e;
    int          i;
    k = '{8'h02, 8'h02, 8'h02, 8'h10, 8'h00};
    w = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h00};
    for (i = 0; i < 5; i++) begin
      axi_wr(sle_pkg::ADR_ACC, {24'h0, w[i]});
      axi_wr(sle_pkg::ADR_INSTR, {18'h0, sle_pkg::OP_SUB_PFX, i[0], k[i]});
      idle(4);
      e = k[i] + ~w[i] + 8'h01;
      axi_rd(sle_pkg::ADR_ACC);
      check(rd, {24'h0, e});
      axi_rd(sle_pkg::ADR_STATUS);
      check(rd, {29'h3, e == 8'h0, k[i][3:0] >= w[i][3:0], k[i] >= w[i]});
    end
    $display("subtract done");
  endtask : t_sub

  task t_refuse;
    axi_wr(sle_pkg::ADR_INSTR, 32'h64);
    idle(4);
    axi_rd(sle_pkg::ADR_ACC);
    check(rd, 32'h0);
    wstrb <= 4'h1;
    axi_wr(sle_pkg::ADR_INSTR, {18'h0, sle_pkg::OP_SLEEP});
    wstrb <= 4'hf;
    idle(6);
    check(halted, 1'b0);
    axi_wr(8'h20, 32'h0);
    check(rs, sle_pkg::RESP_SLVERR);
    axi_rd(8'h20);
    check(rs, sle_pkg::RESP_SLVERR);
    axi_rd(sle_pkg::ADR_STATUS);
    check(rd, 32'h9f);
    $display("refuse done");
  endtask : t_refuse

  task t_sleep(input logic [31:0] st_after);
    axi_rd(sle_pkg::ADR_GUARD);
    check(rd[7:0] != 8'h0, 1'b1);
    axi_wr(sle_pkg::ADR_INSTR, {18'h0, sle_pkg::OP_SLEEP});
    idle(2);
    check(halted, 1'b0);
    idle(1);
    check(halted, 1'b1);
    check(osc_run, 1'b0);
    axi_rd(sle_pkg::ADR_STATUS);
    check(rd, st_after);
    axi_rd(sle_pkg::ADR_GUARD);
    check(rd, 32'h0);
    $display("sleep done");
  endtask : t_sleep

  task t_guard;
    for (n = 0; n < 70000; n++) begin
      @(posedge clk);
      if (gexp) break;
    end
    check(n > 65000 && n < 70000, 1'b1);
    if (n == 70000) begin
      print_verdict();
    end
    idle(2);
    check(halted, 1'b0);
    axi_rd(sle_pkg::ADR_STATUS);
    check(rd, 32'h87);
    idle(600);
    t_sleep(32'hb7);
    axi_wr(sle_pkg::ADR_WAKE, 32'h1);
    idle(2);
    check(halted, 1'b0);
    check(osc_run, 1'b1);
    $display("guard done");
  endtask : t_guard

  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check(osc_run, 1'b1);
    idle(600);
    t_sub();
    t_refuse();
    t_sleep(32'hb7);
    t_guard();
    print_verdict();
  end
endmodule : sle_exec_bench
